/* rtl/lrd_cfg.svh */
/*
 * constants of the link request stream decoder: stream positions, lengths,
 * request type codes and speed codes.
 * assumes it is included by bare name from the decoder sources only.
 */
`ifndef LRD_CFG_SVH
`define LRD_CFG_SVH

// ==========================================================================
// stream positions
`define LRD_POS_START 5'h00
`define LRD_POS_TYPE 5'h01
`define LRD_POS_TYPE_LAST 5'h04
`define LRD_POS_FORMAT 5'h05
`define LRD_POS_SPEED 5'h06
`define LRD_POS_ADDR 5'h05
`define LRD_POS_DATA_HI 5'h09
`define LRD_POS_DATA_LO 5'h0d
`define LRD_POS_SPEED_STOP_OPT 5'h09

// ==========================================================================
// stream lengths in bits
`define LRD_LEN_BUS 5'h0b
`define LRD_LEN_READ 5'h0a
`define LRD_LEN_WRITE 5'h12
`define LRD_LEN_NOTIFY 5'h06
`define LRD_LEN_MAX 18

// ==========================================================================
// request type codes
`define LRD_REQ_IMMEDIATE 4'h1
`define LRD_REQ_NEXT_EVEN 4'h2
`define LRD_REQ_NEXT_ODD 4'h3
`define LRD_REQ_CURRENT 4'h4
`define LRD_REQ_ISO_EVEN 4'h6
`define LRD_REQ_ISO_ODD 4'h7
`define LRD_REQ_CYCLE_START 4'h8
`define LRD_REQ_REG_READ 4'ha
`define LRD_REQ_REG_WRITE 4'hb
`define LRD_REQ_PHASE_EVEN 4'hc
`define LRD_REQ_PHASE_ODD 4'hd
`define LRD_REQ_CYCLE_DUE 4'he

// ==========================================================================
// speed codes; anything above the highest defined code is invalid
`define LRD_SPEED_S100 4'h0
`define LRD_SPEED_S200 4'h2
`define LRD_SPEED_S400 4'h4
`define LRD_SPEED_S800 4'h6

// ==========================================================================
// reset values
`define LRD_REG_RESET 8'h00

`endif

/* rtl/lrd_pkg.sv */
/*
 * types shared by the link request stream decoder.
 * assumes nothing of its surroundings.
 */
package lrd_pkg;

	// ======================================================================
	// receiver states
	typedef enum logic [0:0]
	{
		lrd_wait_start,
		lrd_receiving
	} lrd_state_t;

endpackage

/* rtl/lrd_link_sampler.sv */
/*
 * brings the link clock and the request line into the local clock domain
 * and marks each rising edge of the link clock with a one-cycle strobe.
 * assumes the local clock is several times faster than the link clock.
 */
`timescale 1ns/1ps

module lrd_link_sampler
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic link_clock_in,
	input wire logic link_request_in,
	output logic sample_strobe_out,
	output logic sample_bit_out
);

	// ======================================================================
	// two-stage synchronisers
	logic clock_meta;
	logic clock_sync;
	logic clock_prev;
	logic request_meta;
	logic request_sync;
	logic next_strobe;
	logic next_bit;

	always_comb
	begin
		// both lines see the same delay, so the bit stays aligned to its edge
		next_strobe = clock_sync & ~clock_prev;
		next_bit = next_strobe ? request_sync : sample_bit_out;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			clock_meta <= 1'b0;
			clock_sync <= 1'b0;
			clock_prev <= 1'b0;
			request_meta <= 1'b0;
			request_sync <= 1'b0;
			sample_strobe_out <= 1'b0;
			sample_bit_out <= 1'b0;
		end
		else
		begin
			clock_meta <= link_clock_in;
			clock_sync <= clock_meta;
			clock_prev <= clock_sync;
			request_meta <= link_request_in;
			request_sync <= request_meta;
			sample_strobe_out <= next_strobe;
			sample_bit_out <= next_bit;
		end
	end

endmodule // lrd_link_sampler

/* rtl/lrd_request_decoder.sv */
/*
 * serial link request stream decoder: frames, decodes and acts on requests
 * the link layer controller sends on its request line.
 * assumes the request line is driven on the link returned clock and that
 * arbitration and status transfer logic consume the decoded outputs.
 */
// What this block does
// - each stream opens with a one start bit and ends with a zero stop bit.
// - bits one to four carry the request type code.
// - bits go first-sent most significant; fields arrive high bit first.
// - bus request: eleven bits, format at 5, speed at 6 to 9, stop at 10.
// - register read: ten bits, code 1010, address at 5 to 8, stop at 9.
// - register write is eighteen bits; all are counted before completion.
// - notification and interface reset requests are six bits, no fields.
// - code 0001 starts arbitration as soon as the bus is idle.
// - codes 0010 and 0011 arbitrate for even or odd fairness phase.
// - code 0100 arbitrates within the current fairness interval.
// - codes 0110 and 0111 arbitrate for even or odd isochronous period.
// - code 1000 arbitrates to send a cycle start packet.
// - code 1010 returns the addressed register by a status transfer.
// - code 1011 writes stream data into the addressed register.
// - codes 1100 and 1101 report cycle start seen, phase even or odd.
// - code 1110 reports that a cycle start packet is due.
// - format bit one asks for beta format; zero asks for neither.
// - speeds 0000, 0010, 0100, 0110; 0001, 0011, 0101 reserved; rest invalid.
// - if speed bit 6 is zero the stop bit may be omitted.
// - invalid speed is arbitrated normally but sends a null packet.
// - every bit is sampled on the link returned clock.
// - write request: address 5 to 8, data 9 to 16, stop at 17.
// - an illegal request raises an interface error to the link.
// - while a read is outstanding further reads are ignored.
`timescale 1ns/1ps
`include "lrd_cfg.svh"

module lrd_request_decoder
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic link_returned_clock_in,
	input wire logic link_request_line_in,
	input wire logic read_delivered_in,
	output logic busy_out,
	output logic bus_request_out,
	output logic [3:0] request_type_field_out,
	output logic packet_format_field_out,
	output logic [3:0] request_speed_field_out,
	output logic speed_reserved_out,
	output logic null_packet_out,
	output logic reg_write_out,
	output logic [3:0] reg_write_addr_out,
	output logic [7:0] reg_write_data_out,
	output logic read_pending_out,
	output logic [3:0] read_addr_out,
	output logic [7:0] read_data_out,
	output logic phase_even_out,
	output logic phase_odd_out,
	output logic cycle_start_due_out,
	output logic interface_error_out
);

	// ======================================================================
	// helpers
	function automatic logic [3:0] field4(input logic [`LRD_LEN_MAX-1:0] v,
		input logic [4:0] pos);
		// stream bit pos is the most significant of the field
		field4 = {v[pos], v[pos+5'h01], v[pos+5'h02], v[pos+5'h03]};
	endfunction

	function automatic logic is_bus_code(input logic [3:0] code);
		is_bus_code = (code == `LRD_REQ_IMMEDIATE) || (code == `LRD_REQ_NEXT_EVEN) ||
			(code == `LRD_REQ_NEXT_ODD) || (code == `LRD_REQ_CURRENT) ||
			(code == `LRD_REQ_ISO_EVEN) || (code == `LRD_REQ_ISO_ODD) ||
			(code == `LRD_REQ_CYCLE_START);
	endfunction

	function automatic logic [4:0] stream_len(input logic [3:0] code);
		if (is_bus_code(code))
			stream_len = `LRD_LEN_BUS;
		else if (code == `LRD_REQ_REG_READ)
			stream_len = `LRD_LEN_READ;
		else if (code == `LRD_REQ_REG_WRITE)
			stream_len = `LRD_LEN_WRITE;
		else
			stream_len = `LRD_LEN_NOTIFY;
	endfunction

	// ======================================================================
	// sampling on the link returned clock
	logic sample_strobe;
	logic sample_bit;

	lrd_link_sampler u_sampler
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.link_clock_in(link_returned_clock_in),
		.link_request_in(link_request_line_in),
		.sample_strobe_out(sample_strobe),
		.sample_bit_out(sample_bit)
	);

	// ======================================================================
	// stream receiver and dispatch
	lrd_pkg::lrd_state_t state;
	lrd_pkg::lrd_state_t next_state;
	logic [4:0] bit_index;
	logic [4:0] next_bit_index;
	logic [`LRD_LEN_MAX-1:0] stream_bits;
	logic [`LRD_LEN_MAX-1:0] next_stream_bits;
	logic [7:0] phy_regs [16];
	logic next_busy;
	logic next_bus_request;
	logic [3:0] next_type;
	logic next_format;
	logic [3:0] next_speed;
	logic next_speed_reserved;
	logic next_null_packet;
	logic next_reg_write;
	logic [3:0] next_write_addr;
	logic [7:0] next_write_data;
	logic next_read_pending;
	logic [3:0] next_read_addr;
	logic [7:0] next_read_data;
	logic next_phase_even;
	logic next_phase_odd;
	logic next_cycle_due;
	logic next_error;

	always_comb
	begin
		logic [3:0] code;
		logic [3:0] addr;
		logic [4:0] last_index;
		logic stop_omitted;
		logic done;
		code = 4'h0;
		addr = 4'h0;
		last_index = 5'h00;
		stop_omitted = 1'b0;
		done = 1'b0;
		next_state = state;
		next_bit_index = bit_index;
		next_stream_bits = stream_bits;
		next_bus_request = 1'b0;
		next_type = request_type_field_out;
		next_format = packet_format_field_out;
		next_speed = request_speed_field_out;
		next_speed_reserved = speed_reserved_out;
		next_null_packet = null_packet_out;
		next_reg_write = 1'b0;
		next_write_addr = reg_write_addr_out;
		next_write_data = reg_write_data_out;
		next_read_pending = read_pending_out & ~read_delivered_in;
		next_read_addr = read_addr_out;
		next_read_data = read_data_out;
		next_phase_even = 1'b0;
		next_phase_odd = 1'b0;
		next_cycle_due = 1'b0;
		next_error = 1'b0;
		if (sample_strobe)
		begin
			unique case (state)
				lrd_pkg::lrd_wait_start:
				begin
					// a low line is idle; the first high sample starts a stream
					if (sample_bit)
					begin
						next_state = lrd_pkg::lrd_receiving;
						next_bit_index = 5'h01;
						next_stream_bits = '0;
						next_stream_bits[`LRD_POS_START] = 1'b1;
					end
				end
				lrd_pkg::lrd_receiving:
				begin
					next_stream_bits[bit_index] = sample_bit;
					next_bit_index = bit_index + 5'h01;
					if (bit_index >= `LRD_POS_TYPE_LAST)
					begin
						code = field4(next_stream_bits, `LRD_POS_TYPE);
						last_index = stream_len(code) - 5'h01;
						stop_omitted = is_bus_code(code) &&
							(bit_index == `LRD_POS_SPEED_STOP_OPT) &&
							!next_stream_bits[`LRD_POS_SPEED];
						done = (bit_index == last_index) || stop_omitted;
					end
					if (done)
					begin
						next_state = lrd_pkg::lrd_wait_start;
						if (!stop_omitted && sample_bit)
							next_error = 1'b1;
						else if (is_bus_code(code))
						begin
							// arbitration logic downstream acts on the type code
							next_bus_request = 1'b1;
							next_type = code;
							next_format = next_stream_bits[`LRD_POS_FORMAT];
							next_speed = field4(next_stream_bits, `LRD_POS_SPEED);
							next_speed_reserved = next_speed[0] &&
								(next_speed < `LRD_SPEED_S800);
							next_null_packet = next_speed > `LRD_SPEED_S800;
						end
						else if (code == `LRD_REQ_REG_READ)
						begin
							addr = field4(next_stream_bits, `LRD_POS_ADDR);
							// delivery in the same cycle frees the slot for a new read
							if (!next_read_pending)
							begin
								next_read_pending = 1'b1;
								next_read_addr = addr;
								next_read_data = phy_regs[addr];
							end
						end
						else if (code == `LRD_REQ_REG_WRITE)
						begin
							next_reg_write = 1'b1;
							next_write_addr = field4(next_stream_bits, `LRD_POS_ADDR);
							next_write_data = {field4(next_stream_bits, `LRD_POS_DATA_HI),
								field4(next_stream_bits, `LRD_POS_DATA_LO)};
						end
						else if (code == `LRD_REQ_PHASE_EVEN)
							next_phase_even = 1'b1;
						else if (code == `LRD_REQ_PHASE_ODD)
							next_phase_odd = 1'b1;
						else if (code == `LRD_REQ_CYCLE_DUE)
							next_cycle_due = 1'b1;
						else
							next_error = 1'b1;
					end
				end
			endcase
		end
		next_busy = (next_state == lrd_pkg::lrd_receiving);
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= lrd_pkg::lrd_wait_start;
			bit_index <= 5'h00;
			stream_bits <= '0;
			busy_out <= 1'b0;
			bus_request_out <= 1'b0;
			request_type_field_out <= 4'h0;
			packet_format_field_out <= 1'b0;
			request_speed_field_out <= 4'h0;
			speed_reserved_out <= 1'b0;
			null_packet_out <= 1'b0;
			reg_write_out <= 1'b0;
			reg_write_addr_out <= 4'h0;
			reg_write_data_out <= 8'h00;
			read_pending_out <= 1'b0;
			read_addr_out <= 4'h0;
			read_data_out <= 8'h00;
			phase_even_out <= 1'b0;
			phase_odd_out <= 1'b0;
			cycle_start_due_out <= 1'b0;
			interface_error_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bit_index <= next_bit_index;
			stream_bits <= next_stream_bits;
			busy_out <= next_busy;
			bus_request_out <= next_bus_request;
			request_type_field_out <= next_type;
			packet_format_field_out <= next_format;
			request_speed_field_out <= next_speed;
			speed_reserved_out <= next_speed_reserved;
			null_packet_out <= next_null_packet;
			reg_write_out <= next_reg_write;
			reg_write_addr_out <= next_write_addr;
			reg_write_data_out <= next_write_data;
			read_pending_out <= next_read_pending;
			read_addr_out <= next_read_addr;
			read_data_out <= next_read_data;
			phase_even_out <= next_phase_even;
			phase_odd_out <= next_phase_odd;
			cycle_start_due_out <= next_cycle_due;
			interface_error_out <= next_error;
		end
	end

	// ======================================================================
	// internal register file, written at the edge that raises the write pulse
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < 16; i++)
				phy_regs[i] <= `LRD_REG_RESET;
		end
		else if (next_reg_write)
		begin
			phy_regs[next_write_addr] <= next_write_data;
		end
	end

endmodule // lrd_request_decoder

/* sim/lrd_checker.sv */
/* checker of the request decoder ports: decode outcomes, field levels, read hold.
   assumes it is bound to lrd_request_decoder and that reset is held over an edge. */
`timescale 1ns/1ps
module lrd_checker
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic read_delivered_in,
	input wire logic busy_out,
	input wire logic bus_request_out,
	input wire logic [3:0] request_type_field_out,
	input wire logic [3:0] request_speed_field_out,
	input wire logic speed_reserved_out,
	input wire logic null_packet_out,
	input wire logic reg_write_out,
	input wire logic [3:0] reg_write_addr_out,
	input wire logic [7:0] reg_write_data_out,
	input wire logic read_pending_out,
	input wire logic [3:0] read_addr_out,
	input wire logic [7:0] read_data_out,
	input wire logic phase_even_out,
	input wire logic phase_odd_out,
	input wire logic cycle_start_due_out,
	input wire logic interface_error_out
);
	// ======================================================================
	// properties
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [5:0] pul;
	assign pul = {bus_request_out, reg_write_out, phase_even_out, phase_odd_out,
		cycle_start_due_out, interface_error_out};
	// a pending read that was not delivered in the last cycle must stay put
	sequence s_read_held;
		$past(read_pending_out) && !$past(read_delivered_in);
	endsequence
	AST_ONE_OUTCOME: assert property ($onehot0(pul))
		else $error("more than one decode outcome at once");
	AST_PULSE_SHORT: assert property (|pul |=> pul == 6'h00)
		else $error("decode pulse longer than one cycle");
	AST_BUS_CODE: assert property (bus_request_out |=> request_type_field_out inside
		{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8})
		else $error("bus request with a non arbitration code");
	AST_RESERVED_SPEED: assert property (speed_reserved_out ==
		(request_speed_field_out inside {4'h1, 4'h3, 4'h5}))
		else $error("reserved speed flag wrong");
	AST_NULL_SPEED: assert property (null_packet_out == (request_speed_field_out > 4'h6))
		else $error("null packet flag wrong");
	AST_FIELD_UPDATE: assert property ($changed(request_speed_field_out) ||
		$changed(request_type_field_out) |-> bus_request_out)
		else $error("bus fields changed without a bus request");
	AST_WRITE_UPDATE: assert property ($changed(reg_write_addr_out) ||
		$changed(reg_write_data_out) |-> reg_write_out)
		else $error("write fields changed without a write");
	AST_READ_HELD: assert property (s_read_held |-> read_pending_out &&
		$stable(read_addr_out) && $stable(read_data_out))
		else $error("pending read disturbed");
	AST_READ_CLEAR: assert property ($fell(read_pending_out) |-> $past(read_delivered_in))
		else $error("pending read cleared without delivery");
	AST_STREAM_LEN: assert property ($rose(busy_out) |-> busy_out[*8] ##[1:260] !busy_out)
		else $error("stream reception length out of bounds");
endmodule // lrd_checker

bind lrd_request_decoder lrd_checker u_lrd_checker (.clk_in, .rst_n_in, .read_delivered_in,
	.busy_out, .bus_request_out, .request_type_field_out, .request_speed_field_out,
	.speed_reserved_out, .null_packet_out, .reg_write_out, .reg_write_addr_out,
	.reg_write_data_out, .read_pending_out, .read_addr_out, .read_data_out, .phase_even_out,
	.phase_odd_out, .cycle_start_due_out, .interface_error_out);

/* sim/lrd_link_model.sv */
/* link controller model: drives the request line and the link clock.
   assumes the caller hands the stream left aligned, bit 0 in the top bit. */
`timescale 1ns/1ps
module lrd_link_model
(
	output logic link_clock_out,
	output logic request_out
);
	// ======================================================================
	// stream driver
	initial
	begin
		link_clock_out = 1'b0;
		request_out = 1'b0;
	end
	// the clock stands still between streams, so the decoder sees no stray edges
	task automatic send(input logic [17:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			request_out = bits[17 - i];
			#62.5 link_clock_out = 1'b1;
			#62.5 link_clock_out = 1'b0;
		end
		request_out = 1'b0;
	endtask
endmodule // lrd_link_model

/* sim/lrd_request_decoder_tb.sv */
/* self-checking bench of the request decoder: streams of every kind, checked at the ports.
   assumes the link model sends each bit on one link clock rise. */
`timescale 1ns/1ps
module lrd_request_decoder_tb;
	// ======================================================================
	// signals
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic read_delivered_in = 1'b0;
	logic link_returned_clock_in, link_request_line_in, busy_out, bus_request_out;
	logic packet_format_field_out, speed_reserved_out, null_packet_out, reg_write_out;
	logic read_pending_out, phase_even_out, phase_odd_out, cycle_start_due_out;
	logic interface_error_out, clr = 1'b0;
	logic [3:0] request_type_field_out, request_speed_field_out, reg_write_addr_out, read_addr_out;
	logic [7:0] reg_write_data_out, read_data_out;
	logic [5:0] seen = 6'h00;
	logic [3:0] arb [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
	logic [3:0] rsv [4] = '{4'h0, 4'h5, 4'h9, 4'hf};
	int errors = 0;
	int cmp_count = 0;
	always #5 clk_in = ~clk_in;
	// pulses are gathered so none is missed between compares
	// held clear in reset so unknown outputs before the first edge are not gathered
	always @(posedge clk_in) seen <= (clr || !rst_n_in) ? 6'h00 : seen | {bus_request_out, reg_write_out,
		phase_even_out, phase_odd_out, cycle_start_due_out, interface_error_out};
	lrd_link_model u_lrd_link_model (.link_clock_out(link_returned_clock_in),
		.request_out(link_request_line_in));
	lrd_request_decoder u_lrd_request_decoder (.clk_in, .rst_n_in, .link_returned_clock_in,
		.link_request_line_in, .read_delivered_in, .busy_out, .bus_request_out,
		.request_type_field_out, .packet_format_field_out, .request_speed_field_out,
		.speed_reserved_out, .null_packet_out, .reg_write_out, .reg_write_addr_out,
		.reg_write_data_out, .read_pending_out, .read_addr_out, .read_data_out,
		.phase_even_out, .phase_odd_out, .cycle_start_due_out, .interface_error_out);
	// ======================================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [17:0] bits, input int n, input logic [5:0] exp);
		@(posedge clk_in) clr <= 1'b1;
		@(posedge clk_in) clr <= 1'b0;
		u_lrd_link_model.send(bits, n);
		repeat (15) @(posedge clk_in);
		#1 chk(seen, exp);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ======================================================================
	// tests
	initial
	begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1 chk({busy_out, read_pending_out, null_packet_out, speed_reserved_out, seen}, 0);
		chk({request_type_field_out, request_speed_field_out, reg_write_data_out}, 0);
		$display("test reset done");
		for (int k = 0; k < 16; k++)
		begin
			// speeds below 8 leave the stop bit out
			run({1'b1, arb[k % 7], k[0], k[3:0], 1'b0, 7'h00}, k[3] ? 11 : 10, 6'h20);
			chk({request_type_field_out, packet_format_field_out, request_speed_field_out},
				{arb[k % 7], k[0], k[3:0]});
			chk({speed_reserved_out, null_packet_out}, {k[3:0] inside {1, 3, 5}, k > 6});
		end
		$display("test bus requests done");
		run({1'b1, 4'hb, 4'hf, 8'ha5, 1'b0}, 18, 6'h10);
		chk({reg_write_addr_out, reg_write_data_out}, 12'hfa5);
		run({1'b1, 4'hb, 4'h0, 8'h3c, 1'b0}, 18, 6'h10);
		run({1'b1, 4'ha, 4'hf, 1'b0, 8'h00}, 10, 6'h00);
		chk({read_pending_out, read_addr_out, read_data_out}, 13'h1fa5);
		run({1'b1, 4'ha, 4'h0, 1'b0, 8'h00}, 10, 6'h00);
		chk({read_pending_out, read_addr_out, read_data_out}, 13'h1fa5);
		@(posedge clk_in) read_delivered_in <= 1'b1;
		@(posedge clk_in) read_delivered_in <= 1'b0;
		#1 chk(read_pending_out, 0);
		run({1'b1, 4'ha, 4'h0, 1'b0, 8'h00}, 10, 6'h00);
		chk({read_pending_out, read_addr_out, read_data_out}, 13'h103c);
		// mid-run reset drops the pending read and clears the register file
		@(posedge clk_in) rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1 chk({read_pending_out, read_addr_out, read_data_out}, 0);
		run({1'b1, 4'ha, 4'hf, 1'b0, 8'h00}, 10, 6'h00);
		chk({read_pending_out, read_addr_out, read_data_out}, 13'h1f00);
		$display("test registers done");
		for (int j = 0; j < 4; j++)
			run({1'b1, rsv[j], 1'b0, 12'h000}, 6, 6'h01);
		for (int j = 0; j < 3; j++)
			run({1'b1, 4'hc + j[3:0], 1'b0, 12'h000}, 6, 6'h08 >> j);
		run({1'b1, 4'hc, 1'b1, 12'h000}, 6, 6'h01);
		run({1'b1, 4'he, 1'b0, 12'h000}, 6, 6'h02);
		$display("test notifications done");
		wrap_up();
	end
	initial
	begin
		#200000;
		errors++;
		wrap_up();
	end
endmodule // lrd_request_decoder_tb
